//--- lpmc_cfg.svh
// constants for the low-power mode controller: offsets, bit positions, timing
// assumes the register word is reached over axi4-lite at byte addresses
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH
// ==========================================
// register map
`define LPMC_PWR_CTRL_IDX 8'h87
`define LPMC_PWR_CTRL_ADDR 10'h21C
`define LPMC_STATUS_ADDR 10'h220
`define LPMC_WAKE_EN_ADDR 10'h224
`define LPMC_WDOG_CTRL_ADDR 10'h228
// ==========================================
// fields
`define LPMC_IDLE_BIT 0
`define LPMC_PDOWN_BIT 1
`define LPMC_WDOG_RUN_BIT 4
`define LPMC_PWR_CTRL_RST 8'h00
`define LPMC_WAKE_EN_RST 8'h00
`define LPMC_WDOG_CTRL_RST 8'h00
`define LPMC_NUM_WAKE 6
// ==========================================
// timing: oscillator settle after power-down wake, in ns
`define LPMC_OSC_SETTLE_NS 1000
`define LPMC_CLK_NS 50
`define LPMC_OSC_SETTLE_CYC ((`LPMC_OSC_SETTLE_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`endif

//--- lpmc_pkg.sv
// types for the low-power mode controller
// assumes lpmc_cfg.svh is compiled alongside
package lpmc_pkg;
  typedef enum logic [2:0] {LPMC_RUN, LPMC_IDLE, LPMC_PDOWN, LPMC_SETTLE, LPMC_ISR} lpmc_state_t;
  typedef logic [5:0] lpmc_wake_t;
endpackage

//--- lpmc_low_power_ctrl.sv
// low-power mode controller: idle and power-down sequencing, clock gates, wake
// assumes core holds its state while o_cpu_clk_en is low and an axi4-lite master
// What this block does
// - power-down request stops cpu and peripheral clocks, holds program counter
// - power-down wake clears request, runs waking handler, resumes after request
// - both requests together enter power-down only, never idle afterwards
// - enabled interrupt ends idle, clears idle request, starts handler
// - any reset but software reset ends idle
// - idle preserves all cpu registers and port pin levels
// - requesting instruction is last executed until idle exits
// - power-down stops flash, keeps ram, holds port pin values
// - every reset but software reset ends power-down; pin/por restart vector
// - external interrupt restarts clock; handler waits for stable oscillator
// - wake sources: two external, pin change, watchdog, wake timer, brown-out
`include "lpmc_cfg.svh"
module lpmc_low_power_ctrl
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire lpmc_pkg::lpmc_wake_t i_wake_irq,
  input wire logic i_hw_reset_evt,
  input wire logic i_isr_done,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_osc_stop,
  output logic o_flash_stop,
  output logic o_port_hold,
  output logic o_wake_irq_valid,
  output lpmc_pkg::lpmc_wake_t o_wake_src,
  output logic o_wdt_run_in_sleep,
  output lpmc_pkg::lpmc_state_t o_state
);
  import lpmc_pkg::*;

  // ==========================================
  // registers
  lpmc_state_t state;
  lpmc_state_t next_state;
  logic [7:0] power_control;
  logic [7:0] wake_enable;
  logic [7:0] watchdog_control;
  lpmc_wake_t wake_sync1;
  lpmc_wake_t wake_sync2;
  lpmc_wake_t wake_src;
  logic [15:0] settle_cnt;
  logic aw_held;
  logic w_held;
  logic [9:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ==========================================
  // bus write path
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire hit_pwr = aw_addr == `LPMC_PWR_CTRL_ADDR;
  wire hit_wen = aw_addr == `LPMC_WAKE_EN_ADDR;
  wire hit_wdog = aw_addr == `LPMC_WDOG_CTRL_ADDR;
  wire hit_stat = aw_addr == `LPMC_STATUS_ADDR;
  wire wr_ok = hit_pwr || hit_wen || hit_wdog || hit_stat;
  wire wr_lane0 = do_write && w_strb[0];
  wire pwr_wr = wr_lane0 && hit_pwr && (state == LPMC_RUN || state == LPMC_ISR);

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= 10'h000;
    end
    else if (s_axi_awvalid && !aw_held)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && !w_held)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================
  // bus read path
  wire [7:0] status_word = {3'h0, o_osc_stop, 1'b0, 3'(state)};
  wire [9:0] ra = s_axi_araddr;
  wire rd_hit = ra == `LPMC_PWR_CTRL_ADDR || ra == `LPMC_WAKE_EN_ADDR
    || ra == `LPMC_WDOG_CTRL_ADDR || ra == `LPMC_STATUS_ADDR;
  wire [7:0] rd_byte = ra == `LPMC_PWR_CTRL_ADDR ? power_control
    : ra == `LPMC_WAKE_EN_ADDR ? wake_enable
    : ra == `LPMC_WDOG_CTRL_ADDR ? watchdog_control
    : ra == `LPMC_STATUS_ADDR ? status_word : 8'h00;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================
  // wake synchroniser; first stage feeds only the second
  // synchronise wake
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wake_sync1 <= 6'h00;
      wake_sync2 <= 6'h00;
    end
    else
    begin
      wake_sync1 <= i_wake_irq;
      wake_sync2 <= wake_sync1;
    end
  end

  wire lpmc_wake_t wake_hit = wake_sync2 & wake_enable[5:0];
  wire any_wake = |wake_hit;
  wire settle_done = settle_cnt == 16'(`LPMC_OSC_SETTLE_CYC - 1);

  // ==========================================
  // mode sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      LPMC_RUN:
        if (pwr_wr && w_data[`LPMC_PDOWN_BIT])
          next_state = LPMC_PDOWN;
        else if (pwr_wr && w_data[`LPMC_IDLE_BIT])
          next_state = LPMC_IDLE;
      LPMC_IDLE:
        if (i_hw_reset_evt)
          next_state = LPMC_RUN;
        else if (any_wake)
          next_state = LPMC_ISR;
      LPMC_PDOWN:
        if (i_hw_reset_evt)
          next_state = LPMC_RUN;
        else if (any_wake)
          next_state = LPMC_SETTLE;
      LPMC_SETTLE:
        if (i_hw_reset_evt)
          next_state = LPMC_RUN;
        else if (settle_done)
          next_state = LPMC_ISR;
      LPMC_ISR:
        if (pwr_wr && w_data[`LPMC_PDOWN_BIT])
          next_state = LPMC_PDOWN;
        else if (pwr_wr && w_data[`LPMC_IDLE_BIT])
          next_state = LPMC_IDLE;
        else if (i_isr_done || i_hw_reset_evt)
          next_state = LPMC_RUN;
      default:
        next_state = LPMC_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state <= LPMC_RUN;
    else
      state <= next_state;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      settle_cnt <= 16'h0000;
    else if (state == LPMC_SETTLE)
      settle_cnt <= settle_cnt + 16'h0001;
    else
      settle_cnt <= 16'h0000;
  end

  // latch the waking source for the handler
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wake_src <= 6'h00;
    else if ((state == LPMC_IDLE || state == LPMC_PDOWN) && any_wake)
      wake_src <= wake_hit;
  end

  // ==========================================
  // control registers
  // clear request on wake
  wire leave_low = (state == LPMC_IDLE || state == LPMC_PDOWN || state == LPMC_SETTLE)
    && next_state != state && next_state != LPMC_SETTLE;
  wire [7:0] pwr_wval = w_data[`LPMC_PDOWN_BIT] ? (w_data[7:0] & 8'hFE) : w_data[7:0];

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      power_control <= `LPMC_PWR_CTRL_RST;
    else if (leave_low)
      power_control <= power_control & 8'hFC;
    else if (pwr_wr)
      power_control <= pwr_wval;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wake_enable <= `LPMC_WAKE_EN_RST;
      watchdog_control <= `LPMC_WDOG_CTRL_RST;
    end
    else
    begin
      if (wr_lane0 && hit_wen)
        wake_enable <= w_data[7:0];
      if (wr_lane0 && hit_wdog)
        watchdog_control <= w_data[7:0];
    end
  end

  // ==========================================
  // outputs
  // stop both clocks in power-down and settle, only the cpu clock in idle
  wire in_pdown = state == LPMC_PDOWN;
  assign o_cpu_clk_en = state == LPMC_RUN || state == LPMC_ISR;
  assign o_periph_clk_en = !(in_pdown || state == LPMC_SETTLE);
  assign o_osc_stop = in_pdown;
  assign o_flash_stop = in_pdown || state == LPMC_SETTLE;
  assign o_port_hold = !o_cpu_clk_en;
  assign o_wake_irq_valid = state == LPMC_ISR;
  assign o_wake_src = wake_src;
  assign o_wdt_run_in_sleep = watchdog_control[`LPMC_WDOG_RUN_BIT];
  assign o_state = state;
endmodule

//--- lpmc_properties.sv
// checker for the low-power controller's clock gates and mode sequence
// bound to the controller module lpmc_low_power_ctrl, sees its ports only
`include "lpmc_cfg.svh"
module lpmc_checker
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire lpmc_pkg::lpmc_wake_t i_wake_irq,
  input wire logic i_hw_reset_evt,
  input wire logic i_isr_done,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_osc_stop,
  input wire logic o_flash_stop,
  input wire logic o_port_hold,
  input wire logic o_wake_irq_valid,
  input wire lpmc_pkg::lpmc_wake_t o_wake_src,
  input wire lpmc_pkg::lpmc_state_t o_state
);
  timeunit 1ns;
  timeprecision 1ns;
  import lpmc_pkg::*;
  logic [7:0] n_set;
  logic in_pdown;
  logic in_id;
  assign in_pdown = o_state == LPMC_PDOWN;
  assign in_id = o_state == LPMC_IDLE;
  // counts settle cycles; too large a figure would bloat an unrolled repeat
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      n_set <= 8'h00;
    else
      n_set <= (o_state == LPMC_SETTLE) ? n_set + 8'h01 : 8'h00;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_pdg; in_pdown |-> !o_cpu_clk_en && !o_periph_clk_en && o_osc_stop; endproperty
  a_pdg: assert property (p_pdg) else $error("clock alive in power-down");
  property p_idg; in_id |-> !o_cpu_clk_en && o_periph_clk_en && !o_osc_stop; endproperty
  a_idg: assert property (p_idg) else $error("idle gating wrong");
  property p_hold; in_pdown |-> o_flash_stop && o_port_hold; endproperty
  a_hold: assert property (p_hold) else $error("flash or pins free");
  property p_hwx; (in_pdown || in_id) && i_hw_reset_evt |-> ##[1:3] o_state == LPMC_RUN; endproperty
  a_hwx: assert property (p_hwx) else $error("reset event ignored");
  property p_set; o_state == LPMC_ISR && $past(o_state) == LPMC_SETTLE
    |-> n_set >= `LPMC_OSC_SETTLE_CYC && n_set <= `LPMC_OSC_SETTLE_CYC + 1; endproperty
  a_set: assert property (p_set) else $error("settle length wrong");
  property p_nowk; (in_id && i_wake_irq == 6'h00 && !i_hw_reset_evt)[*4] |=> in_id; endproperty
  a_nowk: assert property (p_nowk) else $error("idle left without cause");
  property p_isrx; o_wake_irq_valid && i_isr_done |=> o_state == LPMC_RUN; endproperty
  a_isrx: assert property (p_isrx) else $error("no resume after handler");
  property p_nidl; o_state == LPMC_SETTLE |=> !in_id; endproperty
  a_nidl: assert property (p_nidl) else $error("idle after power-down");
  property p_src; $rose(o_wake_irq_valid) |-> o_wake_src != 6'h00 && o_cpu_clk_en; endproperty
  a_src: assert property (p_src) else $error("handler without source");
endmodule

//--- lpmc_core_model.sv
// core model: runs the wake handler, then returns after a fixed delay
// follows the controller's wake-valid level
module lpmc_core_model
#(
  parameter int LAT = 8
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_wake_irq_valid,
  output logic o_isr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      cnt <= 0;
      o_isr_done <= 1'h0;
    end
    else if (i_wake_irq_valid && !o_isr_done)
    begin
      cnt <= cnt + 1;
      o_isr_done <= cnt == LAT - 1;
    end
    else
    begin
      cnt <= 0;
      o_isr_done <= 1'h0;
    end
endmodule

//--- test_low_power_mode_control.sv
// bench for the low-power controller: axi4-lite tasks and mode tests
// a core model returns from the handler; the checker is bound to the dut
`include "lpmc_cfg.svh"
module test_low_power_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  import lpmc_pkg::*;
  localparam logic [9:0] PC = `LPMC_PWR_CTRL_ADDR;
  logic i_ref_clk = 1'h0;
  logic i_rst_n, i_hw_reset_evt, i_isr_done, o_wdt_run_in_sleep, o_wake_irq_valid;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic o_cpu_clk_en, o_periph_clk_en, o_osc_stop, o_flash_stop, o_port_hold;
  lpmc_wake_t i_wake_irq, o_wake_src;
  lpmc_state_t o_state;
  int mismatches = 0;
  int samples_checked = 0;
  int k;
  always #25 i_ref_clk = ~i_ref_clk;
  lpmc_low_power_ctrl dut (.i_ref_clk, .i_rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .i_wake_irq, .i_hw_reset_evt, .i_isr_done, .o_cpu_clk_en,
    .o_periph_clk_en, .o_osc_stop, .o_flash_stop, .o_port_hold, .o_wake_irq_valid,
    .o_wake_src, .o_wdt_run_in_sleep, .o_state);
  lpmc_core_model core (.i_ref_clk, .i_rst_n, .i_wake_irq_valid(o_wake_irq_valid),
    .o_isr_done(i_isr_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge i_ref_clk);
      n++;
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
    end
    while (s_axi_bvalid !== 1'h1 && n < 50);
    s_axi_bready <= 1'h0;
    chk({n < 50, s_axi_bresp}, {1'h1, rsp});
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge i_ref_clk);
      n++;
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
    end
    while (s_axi_rvalid !== 1'h1 && n < 50);
    s_axi_rready <= 1'h0;
    chk({n < 50, s_axi_rresp, s_axi_rdata}, {1'h1, rsp, 24'h0, d});
  endtask
  task automatic wait_st(input lpmc_state_t s);
    int n;
    n = 0;
    while (o_state !== s && n < 60)
    begin
      @(posedge i_ref_clk);
      n++;
    end
    chk(o_state, s);
  endtask
  task automatic hw_evt;
    @(posedge i_ref_clk);
    i_hw_reset_evt <= 1'h1;
    @(posedge i_ref_clk);
    i_hw_reset_evt <= 1'h0;
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (6000) @(posedge i_ref_clk);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    {i_rst_n, i_hw_reset_evt, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 54'h0;
    {s_axi_wstrb, i_wake_irq} = 10'h3C0;
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'h1;
    rd(PC, 8'h00, 2'h0);
    rd(`LPMC_WAKE_EN_ADDR, 8'h00, 2'h0);
    rd(10'h3F0, 8'h00, 2'h2);
    wr(10'h3F0, 32'h1, 2'h2);
    wr(`LPMC_WDOG_CTRL_ADDR, 32'h10, 2'h0);
    rd(`LPMC_WDOG_CTRL_ADDR, 8'h10, 2'h0);
    chk(o_wdt_run_in_sleep, 1'h1);
    $display("test registers done");
    wr(PC, 32'h1, 2'h0);
    wait_st(LPMC_IDLE);
    chk({o_cpu_clk_en, o_periph_clk_en, o_port_hold}, 3'h3);
    rd(`LPMC_STATUS_ADDR, 8'h01, 2'h0);
    repeat (5) @(posedge i_ref_clk);
    i_wake_irq <= 6'h04;
    repeat (8) @(posedge i_ref_clk);
    chk(o_state, LPMC_IDLE);
    wr(PC, 32'h0, 2'h0);
    chk(o_state, LPMC_IDLE);
    hw_evt();
    i_wake_irq <= 6'h00;
    wait_st(LPMC_RUN);
    $display("test idle exit done");
    // all six wake sources enabled before power-down, as software must
    wr(`LPMC_WAKE_EN_ADDR, 32'h3F, 2'h0);
    for (k = 0; k < 6; k++)
    begin
      wr(PC, (k == 0) ? 32'h3 : 32'h2, 2'h0);
      wait_st(LPMC_PDOWN);
      chk({o_cpu_clk_en, o_periph_clk_en, o_osc_stop, o_flash_stop, o_port_hold}, 5'h07);
      rd(`LPMC_STATUS_ADDR, 8'h12, 2'h0);
      rd(PC, 8'h02, 2'h0);
      i_wake_irq <= 6'h01 << k;
      wait_st(LPMC_ISR);
      i_wake_irq <= 6'h00;
      chk(o_wake_src, 6'h01 << k);
      rd(PC, 8'h00, 2'h0);
      wait_st(LPMC_RUN);
      repeat (4) @(posedge i_ref_clk);
      chk(o_state, LPMC_RUN);
    end
    wr(PC, 32'h1, 2'h0);
    wait_st(LPMC_IDLE);
    i_wake_irq <= 6'h20;
    wait_st(LPMC_ISR);
    i_wake_irq <= 6'h00;
    rd(PC, 8'h00, 2'h0);
    wait_st(LPMC_RUN);
    wr(PC, 32'h2, 2'h0);
    wait_st(LPMC_PDOWN);
    hw_evt();
    wait_st(LPMC_RUN);
    $display("test wake done");
    end_of_test();
  end
endmodule
bind lpmc_low_power_ctrl lpmc_checker chk_u (.i_ref_clk, .i_rst_n, .i_wake_irq,
  .i_hw_reset_evt, .i_isr_done, .o_cpu_clk_en, .o_periph_clk_en, .o_osc_stop,
  .o_flash_stop, .o_port_hold, .o_wake_irq_valid, .o_wake_src, .o_state);
